/* File: ccap_pkg.sv */
// Purpose: Shared constants for the cache controller processor address path.
// Assumes: One processor clock, synchronous active-high reset.
// Notes: Address widths and the interrupt-controller window live here.
package ccap_pkg;
	// Width of the processor physical address bus.
	localparam int CCAP_AW = 32;
	// Lowest address bit driven during an inquire.
	localparam int CCAP_INQ_LSB = 5;
	// Lowest address bit the processor releases under address hold.
	localparam int CCAP_HOLD_LSB = 3;
	// Number of byte enables on the processor bus.
	localparam int CCAP_BE_W = 8;
	// Interrupt-controller window, inclusive bounds (36-bit space, low 32 bits used).
	localparam logic [31:0] CCAP_INTC_LO = 32'hfee0_0000;
	localparam logic [31:0] CCAP_INTC_HI = 32'hfee0_03ff;
	// Edges from the inquire strobe clock to a synchronised processor check answer.
	localparam int CCAP_CHK_LAT = 5;
	// Controller sequencing states.
	typedef enum logic [2:0] {
		CCAP_IDLE,
		CCAP_HOLD,
		CCAP_DRIVE,
		CCAP_SAMPLE
	} ccap_state_t;
	// Memory bus cycle ownership states.
	typedef enum logic [1:0] {
		CCAP_MB_FREE,
		CCAP_MB_OWN,
		CCAP_MB_COMMIT
	} ccap_mb_t;
endpackage : ccap_pkg

/* File: ccap_addr_path.sv */
// Purpose: Address path of a second-level cache controller at the processor bus.
// Assumes: Processor bus shares mclk; pins are synchronised anyway for safety.
// Notes: Address and parity pins are split into in, out and output enable.
//
// Summary of operation
// - Controller drives inquire address on bits 31:5.
// - Controller asserts address hold for inquires, back-invalidations.
// - Controller drives even parity with inquire strobe.
// - Controller flags a processor address parity error for cycles that start while the inquire sequencer is idle.
// - Decode output active inside interrupt-controller window.
// - Controller owns and may abort before commitment.
// - After commitment controller never aborts the cycle.
// - Commit pin doubles as drive-strength configuration.
// - Shared configuration pin sampled once, at the first clock edge after reset falls.
// - Hash-named signals active low, others active high.
`timescale 1ns/1ps
`default_nettype none
module ccap_addr_path
	import ccap_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic cycle_start_strobe_ctrl_n,
	input wire logic cycle_start_strobe_sram_n,
	input wire logic [CCAP_AW-1:0] cpu_addr_in,
	input wire logic address_parity_in,
	input wire logic [CCAP_BE_W-1:0] byte_enable_n,
	input wire logic cpu_parity_check_n,
	input wire logic transfer_commit_n,
	input wire logic inquire_req,
	input wire logic backinv_req,
	input wire logic [CCAP_AW-1:0] inquire_addr,
	input wire logic mb_cycle_start,
	input wire logic mb_snoop_hit,
	output logic [CCAP_AW-1:0] cpu_addr_out,
	output logic cpu_addr_oe,
	output logic address_parity_out,
	output logic address_parity_oe,
	output logic address_hold,
	output logic external_inquire_strobe_n,
	output logic ctrl_parity_error_n,
	output logic intc_window_decode_n,
	output logic [CCAP_BE_W-1:0] latched_byte_enable_n,
	output logic mb_abort,
	output logic mb_committed,
	output logic drive_strength_cfg,
	output logic inquire_done,
	output logic cpu_check_error
);
	////////////////////////////////////////////////////////////////////////////
	// All state of the block in one record.
	typedef struct packed {
		logic [1:0] ads_sync;                  // Strobe synchroniser, [0] first.
		logic [1:0] bgt_sync;                  // Commit pin synchroniser.
		logic [1:0] chk_sync;                  // Processor parity check synchroniser.
		logic [CCAP_AW-1:0] addr_s1;           // Address first stage.
		logic [CCAP_AW-1:0] addr_s2;           // Address second stage.
		logic [1:0] ap_sync;                   // Parity pin synchroniser.
		logic [CCAP_BE_W-1:0] be_s1;           // Byte enable first stage.
		logic [CCAP_BE_W-1:0] be_s2;           // Byte enable second stage.
		ccap_state_t st;                       // Inquire sequencer.
		ccap_mb_t mb;                          // Memory bus ownership.
		logic [CCAP_AW-1:0] inq_addr;          // Latched inquire address.
		logic inq_kind;                        // High for inquire, low back-invalidate.
		logic cfg_drv;                         // Drive strength strap.
		logic cfg_armed;                       // Strap still to be caught.
		logic perr_n;                          // Registered parity error output.
		logic intc_n;                          // Registered window decode.
		logic [CCAP_BE_W-1:0] be_lat;          // Byte enables of current cycle.
		logic abort;                           // Abort pulse to memory bus logic.
		logic done;                            // Inquire completion pulse.
		logic cpu_err;                         // Processor reported parity error.
		logic [1:0] cfg_fill;                  // Fills with ones as the commit sync fills.
		logic [CCAP_CHK_LAT-1:0] chk_win;      // Marks the clock a check answer is due.
	} ccap_reg_t;

	ccap_reg_t s_q;
	ccap_reg_t s_d;

	// Even parity means the address plus parity has an even count of ones.
	function automatic logic ccap_even(input logic [CCAP_AW-1:0] a);
		ccap_even = ^a[CCAP_AW-1:CCAP_HOLD_LSB];
	endfunction : ccap_even

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block.
	always_comb begin
		logic cyc_start;
		logic commit;
		cyc_start = 1'b0;
		commit = 1'b0;
		s_d = s_q;
		// Pins pass two flops before anything reads them.
		s_d.ads_sync = {s_q.ads_sync[0], ~cycle_start_strobe_ctrl_n};
		s_d.bgt_sync = {s_q.bgt_sync[0], ~transfer_commit_n};
		s_d.chk_sync = {s_q.chk_sync[0], ~cpu_parity_check_n};
		s_d.addr_s1 = cpu_addr_in;
		s_d.addr_s2 = s_q.addr_s1;
		s_d.ap_sync = {s_q.ap_sync[0], address_parity_in};
		s_d.be_s1 = byte_enable_n;
		s_d.be_s2 = s_q.be_s1;
		cyc_start = s_q.ads_sync[1];
		s_d.abort = 1'b0;
		s_d.done = 1'b0;
		// The processor answers two clocks after the strobe, then the pin crosses two flops,
		// so a window bit is walked alongside instead of waiting in a state.
		s_d.chk_win = {s_q.chk_win[CCAP_CHK_LAT-2:0], (s_q.st == CCAP_DRIVE)};
		s_d.cpu_err = s_q.chk_sync[1] && s_q.chk_win[CCAP_CHK_LAT-1];
		// The strap is taken once the synchroniser holds a sample from after reset.
		// Limitation: the strap level must still stand at the first clock edge after reset falls.
		s_d.cfg_fill = {s_q.cfg_fill[0], 1'b1};
		if (s_q.cfg_armed && s_q.cfg_fill[1]) begin
			s_d.cfg_drv = ~s_q.bgt_sync[1];
			s_d.cfg_armed = 1'b0;
		end
		commit = s_q.bgt_sync[1] && !s_q.cfg_armed;
		// Parity, decode and byte enables are taken for each processor cycle that starts while the inquire sequencer is idle.
		if (cyc_start && s_q.st == CCAP_IDLE) begin
			s_d.perr_n = ~(ccap_even(s_q.addr_s2) ^ s_q.ap_sync[1]);
			s_d.intc_n = ~((s_q.addr_s2 >= CCAP_INTC_LO) &&
				(s_q.addr_s2 <= CCAP_INTC_HI));
			s_d.be_lat = s_q.be_s2;
		end
		// Inquire sequencer: hold, drive address and parity, then sample.
		unique case (s_q.st)
			CCAP_IDLE: begin
				if (inquire_req || backinv_req) begin
					s_d.st = CCAP_HOLD;
					s_d.inq_addr = inquire_addr;
					s_d.inq_kind = inquire_req;
				end
			end
			CCAP_HOLD: begin
				// Processor releases the address one clock after hold.
				s_d.st = CCAP_DRIVE;
			end
			CCAP_DRIVE: begin
				s_d.st = CCAP_SAMPLE;
			end
			CCAP_SAMPLE: begin
				// Hold drops once the inquire address and parity have been sampled.
				s_d.st = CCAP_IDLE;
				s_d.done = 1'b1;
			end
		endcase
		// Memory bus ownership: abort only before commitment.
		unique case (s_q.mb)
			CCAP_MB_FREE: begin
				if (mb_cycle_start) begin
					s_d.mb = CCAP_MB_OWN;
				end
			end
			CCAP_MB_OWN: begin
				if (commit) begin
					s_d.mb = CCAP_MB_COMMIT;
				end else if (mb_snoop_hit) begin
					s_d.abort = 1'b1;
					s_d.mb = CCAP_MB_FREE;
				end
			end
			CCAP_MB_COMMIT: begin
				// Controller is free again for new work once committed.
				if (mb_cycle_start) begin
					s_d.mb = CCAP_MB_OWN;
				end else begin
					s_d.mb = CCAP_MB_FREE;
				end
			end
			default: begin
				s_d.mb = CCAP_MB_FREE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset loads constants only.
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= CCAP_IDLE;
			s_q.mb <= CCAP_MB_FREE;
			s_q.cfg_armed <= 1'b1;
			s_q.perr_n <= 1'b1;
			s_q.intc_n <= 1'b1;
			s_q.be_lat <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign address_hold = (s_q.st != CCAP_IDLE);
	assign cpu_addr_oe = (s_q.st == CCAP_DRIVE);
	assign cpu_addr_out = {s_q.inq_addr[CCAP_AW-1:CCAP_INQ_LSB], {CCAP_INQ_LSB{1'b0}}};
	assign address_parity_oe = (s_q.st == CCAP_DRIVE);
	assign address_parity_out = ccap_even(cpu_addr_out);
	assign external_inquire_strobe_n = ~(s_q.st == CCAP_DRIVE);
	assign ctrl_parity_error_n = s_q.perr_n;
	assign intc_window_decode_n = s_q.intc_n;
	assign latched_byte_enable_n = s_q.be_lat;
	assign mb_abort = s_q.abort;
	assign mb_committed = (s_q.mb == CCAP_MB_COMMIT);
	assign drive_strength_cfg = s_q.cfg_drv;
	assign inquire_done = s_q.done;
	assign cpu_check_error = s_q.cpu_err;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_inq_walk;
		(s_q.st == CCAP_HOLD) ##1 cpu_addr_oe ##1 (s_q.st == CCAP_SAMPLE);
	endsequence
	property p_hold_before_drive;
		@(posedge mclk) disable iff (rst) $rose(address_hold) |-> s_inq_walk;
	endproperty
	a_hold_before_drive: assert property (p_hold_before_drive) else $error("hold walk broken");
	property p_addr_with_hold;
		@(posedge mclk) disable iff (rst) cpu_addr_oe |-> address_hold;
	endproperty
	a_addr_with_hold: assert property (p_addr_with_hold) else $error("drive without hold");
	property p_strobe_parity;
		@(posedge mclk) disable iff (rst)
			!external_inquire_strobe_n |-> address_parity_oe && cpu_addr_oe;
	endproperty
	a_strobe_parity: assert property (p_strobe_parity) else $error("parity not with strobe");
	property p_even;
		@(posedge mclk) disable iff (rst)
			address_parity_oe |->
				((^cpu_addr_out[CCAP_AW-1:CCAP_HOLD_LSB]) == address_parity_out);
	endproperty
	a_even: assert property (p_even) else $error("parity not even");
	property p_addr_value;
		@(posedge mclk) disable iff (rst)
			cpu_addr_oe |-> cpu_addr_out[CCAP_AW-1:CCAP_INQ_LSB] ==
				$past(inquire_addr[CCAP_AW-1:CCAP_INQ_LSB], 2);
	endproperty
	a_addr_value: assert property (p_addr_value) else $error("wrong inquire address");
	property p_no_abort_commit;
		@(posedge mclk) disable iff (rst) mb_committed |=> !mb_abort;
	endproperty
	a_no_abort_commit: assert property (p_no_abort_commit) else $error("abort after commit");
	property p_hold_len;
		@(posedge mclk) disable iff (rst) $rose(address_hold) |-> address_hold [*3] ##1 !address_hold;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
	property p_strap;
		@(posedge mclk) $fell(rst) |-> ##3 (drive_strength_cfg == $past(transfer_commit_n, 3));
	endproperty
	a_strap: assert property (p_strap) else $error("strap not caught");
	// A recorded processor check error must trace back to our own inquire strobe.
	property p_cpu_err_window;
		@(posedge mclk) disable iff (rst)
			cpu_check_error |-> $past(!external_inquire_strobe_n, CCAP_CHK_LAT + 1);
	endproperty
	a_cpu_err_window: assert property (p_cpu_err_window) else $error("stray check");
endmodule : ccap_addr_path
`default_nettype wire

/* File: ccap_cpu_model.sv */
// Purpose: Processor and memory bus controller stand-in for the address path.
// Assumes: Shares mclk with the block; pins change just after an edge.
// Notes: The bench resolves the shared address bus from both enables.
`timescale 1ns/1ps
`default_nettype none
module ccap_cpu_model
	import ccap_pkg::*;
(
	input wire logic mclk,
	input wire logic address_hold,
	input wire logic external_inquire_strobe_n,
	input wire logic [CCAP_AW-1:0] bus_addr,
	input wire logic bus_parity,
	input wire logic addr_bit20_mask_n,
	output logic strobe_n,
	output logic [CCAP_AW-1:0] addr_drv,
	output logic parity_drv,
	output logic addr_oe,
	output logic [CCAP_BE_W-1:0] be_n,
	output logic cpu_parity_check_n,
	output logic transfer_commit_n
);
	logic [1:0] chk_q; // Parity-fault pipeline behind a seen inquire strobe.
	initial begin
		strobe_n = 1'b1; // Idle levels are the inactive ones.
		addr_drv = '0;
		parity_drv = 1'b0;
		addr_oe = 1'b0;
		be_n = '1;
		cpu_parity_check_n = 1'b1;
		transfer_commit_n = 1'b1;
		chk_q = '0;
	end
	// One bus cycle; both strobe copies come from this one signal.
	task automatic start_cycle(input logic [CCAP_AW-1:0] a, input logic [7:0] be, input logic bad);
		logic [CCAP_AW-1:0] pa;
		pa = a;
		pa[20] = a[20] & addr_bit20_mask_n; // Bit 20 forced low while masked.
		@(negedge mclk);
		addr_drv = pa;
		parity_drv = ^pa[CCAP_AW-1:CCAP_HOLD_LSB] ^ bad;
		be_n = be;
		addr_oe = 1'b1;
		strobe_n = 1'b0;
		@(negedge mclk);
		strobe_n = 1'b1;
	endtask : start_cycle
	// Commitment from the memory bus side, taken on the falling edge.
	task automatic commit(input logic lvl);
		@(negedge mclk);
		transfer_commit_n = lvl;
	endtask : commit
	// Release the address one clock after hold; report a fault two clocks late.
	always @(posedge mclk) begin
		if (address_hold) begin
			addr_oe <= 1'b0;
		end
		chk_q <= {chk_q[0], !external_inquire_strobe_n && (^bus_addr[31:3] ^ bus_parity)};
		cpu_parity_check_n <= !chk_q[1]; // One clock per fault.
	end
endmodule : ccap_cpu_model
`default_nettype wire

/* File: cache_ctrl_cpu_address_path_tb.sv */
// Purpose: Self-checking bench for the processor address path.
// Assumes: Bench inputs change on the falling edge of mclk; the processor model's check and address release follow the rising edge.
// Notes: Each scenario task drives and judges before it returns.
`timescale 1ns/1ps
`default_nettype none
module cache_ctrl_cpu_address_path_tb;
	import ccap_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, inquire_req = 1'b0, backinv_req = 1'b0;
	logic mb_cycle_start = 1'b0, mb_snoop_hit = 1'b0, m_oe, m_par, m_str, pchk_n, bgt_n;
	logic [31:0] inquire_addr = '0, m_addr, bus_addr, cpu_addr_out, last_addr = '0;
	logic [7:0] m_be, latched_byte_enable_n;
	logic cpu_addr_oe, address_parity_out, address_parity_oe, address_hold, strobe_n;
	logic ctrl_parity_error_n, intc_window_decode_n, mb_abort, mb_committed, drive_strength_cfg;
	logic inquire_done, cpu_check_error, bus_par, last_par = 1'b0;
	logic addr_bit20_mask_n_n = 1'b1, inq_bad = 1'b0;
	int fails = 0, checks = 0;
	always #25 mclk = ~mclk;
	// A bus nobody drives shows the inverse of its last level, not a held value.
	assign bus_addr = cpu_addr_oe ? cpu_addr_out : m_oe ? m_addr : ~last_addr;
	// The inquire parity can be spoiled on its way to provoke a processor check error.
	assign bus_par = address_parity_oe ? address_parity_out ^ inq_bad : m_oe ? m_par : ~last_par;
	always @(posedge mclk) begin
		last_addr <= bus_addr;
		last_par <= bus_par;
	end
	ccap_cpu_model cpu (.mclk(mclk), .address_hold(address_hold),
		.external_inquire_strobe_n(strobe_n), .bus_addr(bus_addr), .bus_parity(bus_par),
		.addr_bit20_mask_n(addr_bit20_mask_n_n),
		.strobe_n(m_str), .addr_drv(m_addr), .parity_drv(m_par), .addr_oe(m_oe), .be_n(m_be),
		.cpu_parity_check_n(pchk_n), .transfer_commit_n(bgt_n));
	ccap_addr_path DUT (.mclk(mclk), .rst(rst), .cycle_start_strobe_ctrl_n(m_str),
		.cycle_start_strobe_sram_n(m_str), .cpu_addr_in(bus_addr), .address_parity_in(bus_par),
		.byte_enable_n(m_be), .cpu_parity_check_n(pchk_n), .transfer_commit_n(bgt_n),
		.inquire_req(inquire_req), .backinv_req(backinv_req), .inquire_addr(inquire_addr),
		.mb_cycle_start(mb_cycle_start), .mb_snoop_hit(mb_snoop_hit),
		.cpu_addr_out(cpu_addr_out), .cpu_addr_oe(cpu_addr_oe),
		.address_parity_out(address_parity_out), .address_parity_oe(address_parity_oe),
		.address_hold(address_hold), .external_inquire_strobe_n(strobe_n),
		.ctrl_parity_error_n(ctrl_parity_error_n), .intc_window_decode_n(intc_window_decode_n),
		.latched_byte_enable_n(latched_byte_enable_n), .mb_abort(mb_abort),
		.mb_committed(mb_committed), .drive_strength_cfg(drive_strength_cfg),
		.inquire_done(inquire_done), .cpu_check_error(cpu_check_error));
	// Compare one value; four-state inequality so an unknown never matches.
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	// Inquire or back-invalidation, judged cycle by cycle along the hand-over walk.
	task automatic t_inquire(input logic bi, input logic [31:0] a, input logic bad);
		logic [3:0] errs;
		errs = '0;
		@(negedge mclk);
		inq_bad = bad;
		inquire_req = !bi;
		backinv_req = bi;
		inquire_addr = a;
		for (int k = 1; k < 5; k++) begin
			@(negedge mclk);
			inquire_req = 1'b0;
			backinv_req = 1'b0;
			check("hold", address_hold, k < 4);
			check("addr_oe", cpu_addr_oe, k == 2);
			check("par_oe", address_parity_oe, k == 2);
			check("strobe_n", strobe_n, k != 2);
			check("done", inquire_done, k == 4);
			if (k == 2) begin
				check("addr", cpu_addr_out, {a[31:5], 5'h00});
				check("even", address_parity_out ^ ^a[31:5], 0);
			end
		end
		inq_bad = 1'b0;
		// The check answer lands five clocks after the processor saw the strobe, as one pulse.
		for (int k = 5; k < 10; k++) begin
			@(negedge mclk);
			errs = errs + cpu_check_error;
		end
		check("cpu_err", errs, bad);
	endtask : t_inquire
	// Processor cycle: decode window edges, byte enables and a parity fault.
	task automatic t_cycle(input logic [31:0] a, input logic bad, input logic in_win, input logic m);
		addr_bit20_mask_n_n = !m;
		cpu.start_cycle(a, a[7:0], bad);
		repeat (3) @(negedge mclk);
		check("decode_n", intc_window_decode_n, !in_win);
		check("perr_n", ctrl_parity_error_n, !bad);
		check("be_n", latched_byte_enable_n, a[7:0]);
	endtask : t_cycle
	// Memory bus cycle start, then a snoop; the abort shows only when uncommitted.
	task automatic t_mbus(input logic com);
		logic ab, cm;
		ab = 1'b0;
		cm = 1'b0;
		@(negedge mclk);
		mb_cycle_start = 1'b1;
		@(negedge mclk);
		mb_cycle_start = 1'b0;
		if (com) begin
			cpu.commit(1'b0);
		end
		// The snoop meets an owned cycle, or the committed clock when commitment came.
		for (int k = 0; k < 6; k++) begin
			@(negedge mclk);
			mb_snoop_hit = (k == 2);
			ab |= mb_abort;
			cm |= mb_committed;
		end
		check("abort", ab, !com);
		check("committed", cm, com);
		if (com) begin
			cpu.commit(1'b1);
		end
	endtask : t_mbus
	initial begin
		repeat (20) @(negedge mclk);
		check("rst_hold", address_hold, 0);
		check("rst_strobe", strobe_n, 1);
		check("rst_decode", intc_window_decode_n, 1);
		check("rst_perr", ctrl_parity_error_n, 1);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		check("strap", drive_strength_cfg, 1);
		t_inquire(1'b0, 32'hfee0_03ff, 1'b0);
		t_inquire(1'b1, 32'h1234_5678, 1'b0);
		t_inquire(1'b0, 32'h0abc_def0, 1'b1);
		t_cycle(32'hfee0_0000, 1'b0, 1'b1, 1'b0);
		t_cycle(32'hfee0_03ff, 1'b0, 1'b1, 1'b0);
		t_cycle(32'hfee0_0400, 1'b0, 1'b0, 1'b0);
		t_cycle(32'hfedf_ffff, 1'b1, 1'b0, 1'b0);
		t_cycle(32'h0000_00a5, 1'b0, 1'b0, 1'b0);
		t_cycle(32'hfef0_0000, 1'b0, 1'b1, 1'b1);
		t_mbus(1'b0);
		t_mbus(1'b1);
		stop_test();
	end
	// Watchdog: the whole sequence needs well under two hundred cycles.
	initial begin
		repeat (2000) @(posedge mclk);
		fails++;
		stop_test();
	end
endmodule : cache_ctrl_cpu_address_path_tb
`default_nettype wire
